//--- verilog/prim_asm_defs.svh
// constants for the primitive assembler
`ifndef PRIM_ASM_DEFS_SVH
`define PRIM_ASM_DEFS_SVH
`define MODE_W        4
`define CMD_W         4
`define RST_BOUNDARY  1'b1
`define SLOT_A        1'b0
`endif

//--- verilog/prim_asm_pkg.sv
// types for the primitive assembler
`default_nettype none
`include "prim_asm_defs.svh"
package prim_asm_pkg;
   typedef enum logic [3:0] {
      MODE_IDLE      = 4'h0,
      MODE_POINTS    = 4'h1,
      MODE_LINES     = 4'h2,
      MODE_LINE_LOOP = 4'h3,
      MODE_LINE_STRIP= 4'h4,
      MODE_TRI       = 4'h5,
      MODE_TRI_STRIP = 4'h6,
      MODE_TRI_FAN   = 4'h7,
      MODE_QUADS     = 4'h8,
      MODE_QUAD_STRIP= 4'h9,
      MODE_POLYGON   = 4'ha
   } draw_mode_type;

   typedef enum logic [3:0] {
      CMD_BEGIN      = 4'h0,
      CMD_END        = 4'h1,
      CMD_VERTEX     = 4'h2,
      CMD_ATTRIB     = 4'h3,
      CMD_ARRAY_ELEM = 4'h4,
      CMD_EVAL       = 4'h5,
      CMD_MATERIAL   = 4'h6,
      CMD_CALL_LIST  = 4'h7,
      CMD_SET_BOUNDARY_BIT = 4'h8,
      CMD_CLIENT_ONLY= 4'h9,
      CMD_OTHER      = 4'hf
   } cmd_code_type;

   typedef struct packed {
      cmd_code_type  code;
      draw_mode_type mode;
      logic          flag;
   } cmd_type;

   typedef struct packed {
      logic [31:0] data;
      logic        boundary;
   } vtx_type;
endpackage : prim_asm_pkg
`default_nettype wire

//--- verilog/cmd_checker.sv
// command legality checker for begin/end brackets
`timescale 1ns/1ps
`default_nettype none
`include "prim_asm_defs.svh"
module cmd_checker
   import prim_asm_pkg::*;
(
   input  wire logic  open_in,
   input  wire cmd_type cmd_in,
   input  wire logic  valid_in,
   input  wire logic  fb_complete_in,
   output logic       begin_ok_out,
   output logic       end_ok_out,
   output logic       inv_op_out,
   output logic       inv_fb_out
);
   // ==========================================================
   // legality
   wire is_begin = valid_in && (cmd_in.code == CMD_BEGIN);
   wire is_end   = valid_in && (cmd_in.code == CMD_END);
   wire allowed  = (cmd_in.code == CMD_VERTEX) || (cmd_in.code == CMD_ATTRIB) ||
                   (cmd_in.code == CMD_ARRAY_ELEM) || (cmd_in.code == CMD_EVAL) ||
                   (cmd_in.code == CMD_MATERIAL) || (cmd_in.code == CMD_CALL_LIST) ||
                   (cmd_in.code == CMD_SET_BOUNDARY_BIT);
   // client-only commands inside a bracket pass silently: behaviour undefined
   wire client   = cmd_in.code == CMD_CLIENT_ONLY; // [RULE_19]
   wire bad_in   = valid_in && open_in && !allowed && !is_begin && !is_end
                   && !client; // [RULE_17]
   wire bad_pair = (is_begin && open_in) || (is_end && !open_in); // [RULE_18]
   wire bad_mode = is_begin && (cmd_in.mode == MODE_IDLE);
   assign inv_fb_out   = is_begin && !open_in && !fb_complete_in; // [RULE_11]
   assign inv_op_out   = bad_in || bad_pair || bad_mode;
   assign begin_ok_out = is_begin && !open_in && fb_complete_in && !bad_mode;
   assign end_ok_out   = is_end && open_in;
endmodule : cmd_checker
`default_nettype wire

//--- verilog/boundary_flag.sv
// current boundary bit and per-vertex edge tag
`timescale 1ns/1ps
`default_nettype none
`include "prim_asm_defs.svh"
module boundary_flag
   import prim_asm_pkg::*;
(
   input  wire logic          sys_clk_in,
   input  wire logic          rst_n_in,
   input  wire logic          ce_in,
   input  wire logic          set_in,
   input  wire logic          flag_in,
   input  wire draw_mode_type mode_in,
   output logic               cur_out,
   output logic               tag_out
);
   logic cur;
   // ==========================================================
   // current bit
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in)
         cur <= `RST_BOUNDARY; // [RULE_15]
      else if (ce_in && set_in)
         cur <= flag_in; // [RULE_12]
   end
   wire flagged_mode = (mode_in == MODE_POLYGON) || (mode_in == MODE_TRI) ||
                       (mode_in == MODE_QUADS);
   assign tag_out = flagged_mode ? cur : 1'b1; // [RULE_13] [RULE_14]
   assign cur_out = cur;
   AST_RESET_TRUE: assert property (@(posedge sys_clk_in) // [RULE_15]
      !rst_n_in |=> cur) else $error("boundary bit not set after reset");
   AST_SET_ZERO: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // [RULE_12]
      ce_in && set_in |=> cur == $past(flag_in))
      else $error("boundary bit not loaded");
   AST_FIXED_MODES: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // [RULE_14]
      !flagged_mode |-> tag_out) else $error("strip edge not boundary");
endmodule : boundary_flag
`default_nettype wire

//--- verilog/primitive_assembler.sv
// primitive assembler: triangles and quads from a bracketed vertex stream
`timescale 1ns/1ps
`default_nettype none
`include "prim_asm_defs.svh"
// Summary of operation
// [RULE_01] strip keeps slots A,B and a pointer; begin points A, each vertex toggles
// [RULE_02] strip: third vertex on emits A, B, new; first-done flag recorded
// [RULE_03] fan: like strip but vertices after first overwrite B
// [RULE_04] separate triangles from groups of three; leftovers dropped
// [RULE_05] separate triangles: group first is A, second is B
// [RULE_06] quad strip: quad i is v2i, v2i+1, v2i+3, v2i+2
// [RULE_07] quad strip keeps three vertices, first-done flag, pair counter
// [RULE_08] quad strip: nothing under four vertices; odd last vertex dropped
// [RULE_09] separate quads from groups of four; remainder dropped
// [RULE_10] mode register holds ten modes plus idle
// [RULE_11] begin with incomplete draw target raises framebuffer error
// [RULE_12] boundary command clears bit on zero, sets otherwise
// [RULE_13] polygon, triangles, quads: edge tag follows current bit
// [RULE_14] all other modes tag every edge boundary
// [RULE_15] boundary bit resets to set
// [RULE_16] each assembled vertex carries its edge boundary tag
// [RULE_17] only listed commands allowed inside bracket, else invalid operation
// [RULE_18] nested begin or unmatched end gives invalid operation
// [RULE_19] client-state commands forbidden inside bracket, no error guaranteed
// [RULE_20] strip closed with under three vertices emits nothing
// [RULE_21] reset and accepted end return mode to idle and clear state
module primitive_assembler
   import prim_asm_pkg::*;
#(
   parameter int VTX_W = 32
)(
   input  wire logic             sys_clk_in,
   input  wire logic             rst_n_in,
   input  wire logic             ce_in,
   input  wire logic             cmd_valid_in,
   input  wire cmd_type          cmd_in,
   input  wire logic [VTX_W-1:0] vtx_data_in,
   input  wire logic             bound_draw_target_complete_in,
   output logic                  prim_valid_out,
   output logic                  prim_quad_out,
   output vtx_type               prim_v0_out,
   output vtx_type               prim_v1_out,
   output vtx_type               prim_v2_out,
   output vtx_type               prim_v3_out,
   output logic                  inv_op_out,
   output logic                  inv_fb_out,
   output draw_mode_type         mode_out,
   output logic                  boundary_bit_out
);
   // ==========================================================
   // state
   draw_mode_type mode;
   vtx_type       slot_a;
   vtx_type       slot_b;
   vtx_type       slot_c;
   logic          ptr;
   logic          first_done;
   logic          pair_cnt;
   logic [1:0]    grp_cnt;
   logic          inv_op;
   logic          inv_fb;
   logic          prim_valid;
   logic          prim_quad;
   vtx_type       v0, v1, v2, v3;

   wire open = mode != MODE_IDLE;
   wire begin_ok, end_ok, chk_op, chk_fb;
   wire tag, cur_bit;

   // ==========================================================
   // sub-blocks
   cmd_checker u_chk (
      .open_in        (open),
      .cmd_in         (cmd_in),
      .valid_in       (cmd_valid_in),
      .fb_complete_in (bound_draw_target_complete_in),
      .begin_ok_out   (begin_ok),
      .end_ok_out     (end_ok),
      .inv_op_out     (chk_op),
      .inv_fb_out     (chk_fb)
   );

   wire set_cmd = cmd_valid_in && (cmd_in.code == CMD_SET_BOUNDARY_BIT);
   boundary_flag u_bnd (
      .sys_clk_in (sys_clk_in),
      .rst_n_in   (rst_n_in),
      .ce_in      (ce_in),
      .set_in     (set_cmd),
      .flag_in    (cmd_in.flag),
      .mode_in    (mode),
      .cur_out    (cur_bit),
      .tag_out    (tag)
   );

   // ==========================================================
   // vertex decode
   wire     vtx   = cmd_valid_in && open && (cmd_in.code == CMD_VERTEX);
   vtx_type nv;
   assign nv = '{data: vtx_data_in, boundary: tag}; // [RULE_16]

   wire is_strip = mode == MODE_TRI_STRIP;
   wire is_fan   = mode == MODE_TRI_FAN;
   wire is_tri   = mode == MODE_TRI;
   wire is_qs    = mode == MODE_QUAD_STRIP;
   wire is_quads = mode == MODE_QUADS;

   // strip/fan emit once two vertices stored
   wire sf_emit  = vtx && (is_strip || is_fan) && (first_done || (ptr == 1'b0 &&
                   grp_cnt == 2'd2)); // [RULE_02] [RULE_20]
   wire tri_emit = vtx && is_tri && (grp_cnt == 2'd2); // [RULE_04]
   // quad strip: emit on second of each pair after the first pair
   wire qs_emit  = vtx && is_qs && pair_cnt && first_done; // [RULE_06] [RULE_08]
   wire qd_emit  = vtx && is_quads && (grp_cnt == 2'd3); // [RULE_09]

   // ==========================================================
   // mode and counters
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         mode       <= MODE_IDLE; // [RULE_21]
         ptr        <= `SLOT_A;
         first_done <= 1'b0;
         pair_cnt   <= 1'b0;
         grp_cnt    <= 2'd0;
      end else if (ce_in) begin
         if (begin_ok) begin
            mode       <= cmd_in.mode; // [RULE_10]
            ptr        <= `SLOT_A; // [RULE_01]
            first_done <= 1'b0;
            pair_cnt   <= 1'b0;
            grp_cnt    <= 2'd0;
         end else if (end_ok) begin
            mode       <= MODE_IDLE; // [RULE_21]
            ptr        <= `SLOT_A;
            first_done <= 1'b0;
            pair_cnt   <= 1'b0;
            grp_cnt    <= 2'd0;
         end else if (vtx) begin
            ptr      <= ~ptr; // [RULE_01]
            pair_cnt <= ~pair_cnt; // [RULE_07]
            if (is_tri)
               grp_cnt <= (grp_cnt == 2'd2) ? 2'd0 : grp_cnt + 2'd1; // [RULE_04]
            else if (grp_cnt != 2'd3 || is_quads)
               grp_cnt <= grp_cnt + 2'd1;
            if (sf_emit)
               first_done <= 1'b1; // [RULE_02]
            if (is_qs && pair_cnt)
               first_done <= 1'b1; // [RULE_07]
         end
      end
   end

   // ==========================================================
   // vertex slots
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         slot_a <= '0;
         slot_b <= '0;
         slot_c <= '0;
      end else if (ce_in && vtx) begin
         if (is_strip) begin
            if (ptr == `SLOT_A)
               slot_a <= nv; // [RULE_01]
            else
               slot_b <= nv;
         end else if (is_fan) begin
            if (grp_cnt == 2'd0)
               slot_a <= nv; // [RULE_03]
            else
               slot_b <= nv; // [RULE_03]
         end else if (is_tri) begin
            if (grp_cnt == 2'd0)
               slot_a <= nv; // [RULE_05]
            if (grp_cnt == 2'd1)
               slot_b <= nv; // [RULE_05]
         end else if (is_qs) begin
            // a,b = previous pair; c = first of current pair
            if (!pair_cnt)
               slot_c <= nv; // [RULE_07]
            else begin
               slot_a <= slot_c;
               slot_b <= nv;
            end
         end else if (is_quads) begin
            if (grp_cnt == 2'd0)
               slot_a <= nv;
            if (grp_cnt == 2'd1)
               slot_b <= nv;
            if (grp_cnt == 2'd2)
               slot_c <= nv;
         end
      end
   end

   // ==========================================================
   // output primitive, registered
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         prim_valid <= 1'b0;
         prim_quad  <= 1'b0;
         v0 <= '0;
         v1 <= '0;
         v2 <= '0;
         v3 <= '0;
         inv_op <= 1'b0;
         inv_fb <= 1'b0;
      end else if (ce_in) begin
         inv_op     <= chk_op; // [RULE_17] [RULE_18]
         inv_fb     <= chk_fb; // [RULE_11]
         prim_valid <= sf_emit || tri_emit || qs_emit || qd_emit;
         prim_quad  <= qs_emit || qd_emit;
         if (sf_emit || tri_emit) begin
            v0 <= slot_a; // [RULE_02]
            v1 <= slot_b;
            v2 <= nv;
            v3 <= '0;
         end else if (qs_emit) begin
            // v2i, v2i+1, v2i+3, v2i+2
            v0 <= slot_a; // [RULE_06]
            v1 <= slot_b;
            v2 <= nv;
            v3 <= slot_c;
         end else if (qd_emit) begin
            v0 <= slot_a; // [RULE_09]
            v1 <= slot_b;
            v2 <= slot_c;
            v3 <= nv;
         end
      end
   end

   assign prim_valid_out   = prim_valid;
   assign prim_quad_out    = prim_quad;
   assign prim_v0_out      = v0;
   assign prim_v1_out      = v1;
   assign prim_v2_out      = v2;
   assign prim_v3_out      = v3;
   assign inv_op_out       = inv_op;
   assign inv_fb_out       = inv_fb;
   assign mode_out         = mode;
   assign boundary_bit_out = cur_bit;

   // ==========================================================
   // checks: triangle strips and fans
   AST_BEGIN_PTR: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // [RULE_01]
      ce_in && begin_ok |=> ptr == 1'b0 && !first_done)
      else $error("pointer not reset by begin");

   AST_STRIP_PTR: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // [RULE_01]
      ce_in && vtx && is_strip |=> ptr != $past(ptr))
      else $error("strip pointer not toggled");

   AST_STRIP_SLOT: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // [RULE_01]
      ce_in && vtx && is_strip && ptr == 1'b0 |=> slot_a == $past(nv))
      else $error("strip vertex not stored in slot a");

   AST_STRIP_FEW: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // [RULE_20]
      ce_in && begin_ok && cmd_in.mode == MODE_TRI_STRIP ##1 (ce_in && vtx)
      ##1 (ce_in && vtx) |=> !prim_valid)
      else $error("strip emitted before third vertex");

   AST_FAN_KEEP_A: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // [RULE_03]
      ce_in && vtx && is_fan && grp_cnt != 2'd0 |=> slot_a == $past(slot_a))
      else $error("fan first vertex overwritten");

   AST_TRI_ZERO_V3: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // [RULE_02]
      prim_valid && !prim_quad |-> v3 == '0)
      else $error("triangle carries a fourth vertex");

   AST_NO_VTX_QUIET: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // [RULE_02]
      ce_in && !vtx |=> !prim_valid)
      else $error("primitive without a vertex");

   // ==========================================================
   // checks: separate triangles and quads
   AST_TRI_ORDER: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // [RULE_04]
      ce_in && tri_emit |=> prim_valid && !prim_quad && v2 == $past(nv))
      else $error("separate triangle wrong");

   AST_TRI_WRAP: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // [RULE_04]
      ce_in && vtx && is_tri && grp_cnt == 2'd2 |=> grp_cnt == 2'd0)
      else $error("triangle group count not wrapped");

   AST_QUAD_EMIT: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // [RULE_09]
      ce_in && qd_emit |=> prim_quad && v3 == $past(nv))
      else $error("quad not emitted");

   AST_QUAD_COUNT: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // [RULE_09]
      ce_in && vtx && is_quads |=> grp_cnt == $past(grp_cnt) + 2'd1)
      else $error("quad group count not advanced");

   AST_QS_ORDER: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // [RULE_06]
      ce_in && qs_emit |=> v3 == $past(slot_c) && v2 == $past(nv))
      else $error("quad strip order wrong");

   AST_QS_DONE: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // [RULE_07]
      ce_in && vtx && is_qs && pair_cnt |=> first_done)
      else $error("quad strip first pair not recorded");

   AST_QS_SLIDE: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // [RULE_07]
      ce_in && vtx && is_qs && pair_cnt |=> slot_a == $past(slot_c) && slot_b == $past(nv))
      else $error("quad strip pair not kept");

   AST_FIXED_TAG: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // [RULE_16]
      vtx && (is_strip || is_fan || is_qs) |-> nv.boundary)
      else $error("strip vertex not tagged boundary");

   // ==========================================================
   // checks: commands and mode register
   AST_BEGIN_MODE: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // [RULE_10]
      ce_in && begin_ok |=> mode == $past(cmd_in.mode))
      else $error("begin did not load the mode");

   // a frozen cycle must not move the bracket state
   AST_CE_FREEZE: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // [RULE_10]
      !ce_in |=> mode == $past(mode) && slot_a == $past(slot_a))
      else $error("state moved while clock enable low");

   AST_END_IDLE: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // [RULE_21]
      ce_in && end_ok |=> mode == MODE_IDLE && grp_cnt == 2'd0)
      else $error("end did not return to idle");

   AST_NESTED_BEGIN: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // [RULE_18]
      ce_in && cmd_valid_in && cmd_in.code == CMD_BEGIN && open |=> inv_op)
      else $error("nested begin not flagged");

   AST_LONE_END: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // [RULE_18]
      ce_in && cmd_valid_in && cmd_in.code == CMD_END && !open |=> inv_op)
      else $error("unmatched end not flagged");

   AST_FB_ERR: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // [RULE_11]
      ce_in && chk_fb |=> inv_fb && mode == MODE_IDLE)
      else $error("incomplete target begin accepted");

   AST_BAD_CMD: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // [RULE_17]
      ce_in && cmd_valid_in && open && cmd_in.code == CMD_OTHER |=> inv_op)
      else $error("illegal command not flagged");
endmodule : primitive_assembler
`default_nettype wire

//--- tb/raster_sink.sv
// rasterizer-side model that captures every assembled primitive
`timescale 1ns/1ps
`default_nettype none
module raster_sink
   import prim_asm_pkg::*;
(
   input  wire logic          sys_clk_in,
   input  wire logic          clear_in,
   input  wire logic          prim_valid_in,
   input  wire logic          prim_quad_in,
   input  wire vtx_type       v0_in,
   input  wire vtx_type       v1_in,
   input  wire vtx_type       v2_in,
   input  wire vtx_type       v3_in,
   input  wire logic [2:0]    idx_in,
   output logic [3:0]         count_out,
   output logic [132:0]       entry_out
);
   logic [132:0] store [8];
   // never stalls: the assembler has no back-pressure input
   always_ff @(posedge sys_clk_in) begin
      if (clear_in) begin
         count_out <= 4'h0;
      end else if (prim_valid_in === 1'b1) begin
         store[count_out[2:0]] <= {prim_quad_in, v0_in, v1_in, v2_in, v3_in};
         count_out <= count_out + 4'h1;
      end
   end
   assign entry_out = store[idx_in];
endmodule // raster_sink
`default_nettype wire

//--- tb/primitive_assembler_test.sv
// self-checking bench for the primitive assembler
`timescale 1ns/1ps
`default_nettype none
module primitive_assembler_test
   import prim_asm_pkg::*;
;
   logic          sys_clk = 1'b0;
   logic          rst_n = 1'b0;
   logic          cmd_valid = 1'b0;
   cmd_type       cmd = '0;
   logic [31:0]   vtx_data = 32'h0000_0000;
   logic          fb_ok = 1'b1;
   logic          ce = 1'b1;
   logic          clr = 1'b1;
   logic [2:0]    sink_idx = 3'h0;
   logic          p_valid, p_quad, inv_op, inv_fb, bbit;
   vtx_type       p_v0, p_v1, p_v2, p_v3;
   draw_mode_type mode;
   logic [3:0]    cnt;
   logic [132:0]  entry;
   int            fail_count = 0;
   int            num_checks = 0;
   int            n_op = 0;
   int            n_fb = 0;
   always #5 sys_clk = ~sys_clk;
   primitive_assembler u_dut (.sys_clk_in(sys_clk), .rst_n_in(rst_n), .ce_in(ce),
      .cmd_valid_in(cmd_valid), .cmd_in(cmd), .vtx_data_in(vtx_data),
      .bound_draw_target_complete_in(fb_ok), .prim_valid_out(p_valid),
      .prim_quad_out(p_quad), .prim_v0_out(p_v0), .prim_v1_out(p_v1),
      .prim_v2_out(p_v2), .prim_v3_out(p_v3), .inv_op_out(inv_op),
      .inv_fb_out(inv_fb), .mode_out(mode), .boundary_bit_out(bbit));
   raster_sink u_sink (.sys_clk_in(sys_clk), .clear_in(clr), .prim_valid_in(p_valid),
      .prim_quad_in(p_quad), .v0_in(p_v0), .v1_in(p_v1), .v2_in(p_v2),
      .v3_in(p_v3), .idx_in(sink_idx), .count_out(cnt), .entry_out(entry));
   // error pulses stand one cycle, so count them at every edge
   always @(posedge sys_clk) begin
      if (inv_op === 1'b1) n_op++;
      if (inv_fb === 1'b1) n_fb++;
   end
   task automatic close_out;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic chk_bit(input string nm, input logic e, input logic g);
      num_checks++;
      if (g !== e) begin
         $display("wrong value %s expected %b seen %b", nm, e, g);
         fail_count++;
      end
   endtask
   task automatic chk_mode(input draw_mode_type e);
      num_checks++;
      if (mode !== e) begin
         $display("wrong value mode expected %h seen %h", e, mode);
         fail_count++;
      end
   endtask
   task automatic chk_num(input string nm, input logic [7:0] e, input logic [7:0] g);
      num_checks++;
      if (g !== e) begin
         $display("wrong value %s expected %0d seen %0d", nm, e, g);
         fail_count++;
      end
   endtask
   task automatic chk_prim(input int i, input logic [132:0] e);
      sink_idx = i[2:0];
      #1;
      num_checks++;
      if (entry !== e) begin
         $display("wrong value prim %0d expected %h seen %h", i, e, entry);
         fail_count++;
      end
   endtask
   function automatic logic [132:0] pr(input logic q, input logic [31:0] a, b, c, d,
                                       input logic [3:0] bt);
      pr = {q, a, bt[3], b, bt[2], c, bt[1], d, bt[0]};
   endfunction
   task automatic send(input cmd_code_type c, input draw_mode_type m, input logic f,
                       input logic [31:0] d);
      @(posedge sys_clk);
      cmd <= '{code: c, mode: m, flag: f};
      vtx_data <= d;
      cmd_valid <= 1'b1;
   endtask
   task automatic idle(input int n);
      repeat (n) begin
         @(posedge sys_clk);
         cmd_valid <= 1'b0;
      end
   endtask
   task automatic verts(input int first, input int last);
      for (int v = first; v <= last; v++) send(CMD_VERTEX, MODE_IDLE, 1'b0, v);
   endtask
   task automatic flag(input logic f);
      send(CMD_SET_BOUNDARY_BIT, MODE_IDLE, f, 32'h0000_0000);
   endtask
   task automatic open(input draw_mode_type m);
      @(posedge sys_clk);
      clr <= 1'b1;
      cmd_valid <= 1'b0;
      send(CMD_BEGIN, m, 1'b0, 32'h0000_0000);
      clr <= 1'b0;
   endtask
   task automatic fin(input int n);
      send(CMD_END, MODE_IDLE, 1'b0, 32'h0000_0000);
      idle(3);
      #1;
      chk_num("prim count", n, cnt);
      chk_mode(MODE_IDLE);
   endtask
   // ==========================================
   // scenarios
   task automatic t_reset;
      #1;
      chk_mode(MODE_IDLE);
      chk_bit("boundary bit", 1'b1, bbit);
      chk_bit("prim valid", 1'b0, p_valid);
   endtask
   task automatic t_strip;
      open(MODE_TRI_STRIP);
      flag(1'b0);
      verts(1, 5);
      fin(3);
      chk_bit("boundary bit", 1'b0, bbit);
      chk_prim(0, pr(1'b0, 1, 2, 3, 0, 4'he));
      chk_prim(1, pr(1'b0, 3, 2, 4, 0, 4'he));
      chk_prim(2, pr(1'b0, 3, 4, 5, 0, 4'he));
   endtask
   task automatic t_short;
      open(MODE_TRI_STRIP);
      verts(1, 2);
      fin(0);
      open(MODE_QUAD_STRIP);
      verts(1, 3);
      fin(0);
   endtask
   task automatic t_fan;
      open(MODE_TRI_FAN);
      verts(1, 2);
      // vertex offered while frozen must be lost
      send(CMD_VERTEX, MODE_IDLE, 1'b0, 32'h0000_0063);
      ce <= 1'b0;
      idle(2);
      ce <= 1'b1;
      verts(3, 4);
      fin(2);
      chk_prim(0, pr(1'b0, 1, 2, 3, 0, 4'he));
      chk_prim(1, pr(1'b0, 1, 3, 4, 0, 4'he));
   endtask
   task automatic t_tris;
      open(MODE_TRI);
      flag(1'b1);
      verts(1, 1);
      flag(1'b0);
      verts(2, 2);
      flag(1'b1);
      verts(3, 7);
      fin(2);
      chk_prim(0, pr(1'b0, 1, 2, 3, 0, 4'ha));
      chk_prim(1, pr(1'b0, 4, 5, 6, 0, 4'he));
   endtask
   task automatic t_quads;
      open(MODE_QUAD_STRIP);
      flag(1'b0);
      verts(1, 7);
      fin(2);
      chk_prim(0, pr(1'b1, 1, 2, 4, 3, 4'hf));
      chk_prim(1, pr(1'b1, 3, 4, 6, 5, 4'hf));
      open(MODE_QUADS);
      verts(1, 7);
      fin(1);
      chk_prim(0, pr(1'b1, 1, 2, 3, 4, 4'h0));
   endtask
   task automatic t_errors;
      int op0;
      op0 = n_op;
      send(CMD_END, MODE_IDLE, 1'b0, 32'h0000_0000);
      send(CMD_BEGIN, MODE_TRI, 1'b0, 32'h0000_0000);
      fb_ok <= 1'b0;
      idle(1);
      fb_ok <= 1'b1;
      idle(2);
      #1;
      chk_num("fb errors", 1, n_fb);
      chk_num("op errors", op0 + 1, n_op);
      chk_mode(MODE_IDLE);
      open(MODE_TRI);
      send(CMD_BEGIN, MODE_QUADS, 1'b0, 32'h0000_0000);
      // client-only code stays outside the bracket
      for (int c = 3; c <= 8; c++) send(cmd_code_type'(4'(c)), MODE_IDLE, 1'b1, 0);
      idle(3);
      #1;
      chk_num("op errors", op0 + 2, n_op);
      chk_mode(MODE_TRI);
      send(CMD_OTHER, MODE_IDLE, 1'b0, 32'h0000_0000);
      idle(3);
      #1;
      chk_num("op errors", op0 + 3, n_op);
      fin(0);
   endtask
   task automatic t_modes;
      for (int m = 1; m <= 10; m++) begin
         open(draw_mode_type'(4'(m)));
         idle(2);
         chk_mode(draw_mode_type'(4'(m)));
         fin(0);
      end
   endtask
   initial begin
      repeat (5) @(posedge sys_clk);
      rst_n <= 1'b1;
      t_reset();
      t_strip();
      t_short();
      t_fan();
      t_tris();
      t_quads();
      t_errors();
      t_modes();
      close_out();
   end
   initial begin
      repeat (20000) @(posedge sys_clk);
      fail_count++;
      close_out();
   end
endmodule // primitive_assembler_test
`default_nettype wire
